// *** logic/phc_defines.vh ***
// Constants for the PLL holdover controller: offsets, fields, reset values, timing.
`ifndef PHC_DEFINES_VH
`define PHC_DEFINES_VH
// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define PHC_IDX_LOCK_DETECT_CONFIG   9'h018
`define PHC_IDX_LOCK_PIN_CONTROL     9'h01A
`define PHC_IDX_REFERENCE_SELECT     9'h01C
`define PHC_IDX_HOLDOVER_CONTROL     9'h01D
`define PHC_IDX_REF_MON_THRESHOLD    9'h01F
`define PHC_IDX_STATUS               9'h020
`define PHC_IDX_CH0_CONTROL          9'h191
`define PHC_IDX_CH_STRIDE            9'h003
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PHC_LDC_CNT_HI      6
`define PHC_LDC_CNT_LO      5
`define PHC_LDC_WINDOW      4
`define PHC_LDC_DISABLE     3
`define PHC_LPC_MODE_HI     5
`define PHC_RSC_AUTO        4
`define PHC_RSC_PREFER_B    3
`define PHC_RSC_BUF_B       2
`define PHC_RSC_BUF_A       1
`define PHC_HOC_COMP_EN     3
`define PHC_HOC_EXTERNAL    1
`define PHC_HOC_ENABLE      0
`define PHC_RMT_EXT_A       1
`define PHC_RMT_EXT_B       2
`define PHC_CH_IGNORE_ALIGN 6
// ----------------------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------------------
`define PHC_LPC_CURRENT_SRC 6'h04
`define PHC_LPC_DIGITAL     6'h01
`define PHC_RST_LDC         8'h00
`define PHC_RST_LPC         8'h00
`define PHC_RST_RSC         8'h06
`define PHC_RST_HOC         8'h00
`define PHC_RST_RMT         8'h00
`define PHC_RST_CH          8'h00
`define PHC_LOCK_CNT_00     8'h05
`define PHC_LOCK_CNT_01     8'h10
`define PHC_LOCK_CNT_10     8'h40
`define PHC_LOCK_CNT_11     8'hFF
// ----------------------------------------------------------------------------
// Timing, in ns and derived cycles at the 125 MHz clock
// ----------------------------------------------------------------------------
`define PHC_CLK_PERIOD_NS   8
`define PHC_LOCK_WIN_HI_NS  24
`define PHC_LOCK_WIN_LO_NS  8
`define PHC_UNLOCK_HI_NS    48
`define PHC_UNLOCK_LO_NS    24
`define PHC_MON_NORM_NS     400
`define PHC_MON_EXT_NS      4000
`define PHC_MON_CLK_NS      400
// Cycle counts are the ns figures over the clock period, sized to the counters using them.
`define PHC_LOCK_WIN_HI_CYC 8'h03
`define PHC_LOCK_WIN_LO_CYC 8'h01
`define PHC_UNLOCK_HI_CYC   8'h06
`define PHC_UNLOCK_LO_CYC   8'h03
`define PHC_MON_NORM_CYC    10'h032
`define PHC_MON_EXT_CYC     10'h1F4
`define PHC_MON_CLK_CYC     10'h032
`endif

// *** logic/phc_holdover.v ***
// PLL holdover controller with lock detect, reference select and frequency monitors.
`timescale 1ns/100ps
// Overview of operation
// - Holdover enable bit gates both holdover modes.
// - Charge pump goes high impedance during holdover.
// - Manual mode enters holdover on alignment falling edge.
// - Manual exit only on next reference detector edge.
// - Exit resets B counter, prescaler untouched.
// - External control bit picks manual or automatic.
// - Clear ignore bit: alignment low stops outputs.
// - Automatic mode enters holdover on low lock pin.
// - Comparator disabled means lock pin reads high.
// - Automatic holdover holds while reference edges absent.
// - No re-entry until lock pin high again.
// - Holdover follows selected reference; switchover hold brief.
// - Counter field sets lock cycles; 00 is five.
// - Code 000100b selects current-source lock output.
// - Window bit clear selects high range window.
// - Select register: auto switch, preference, buffer enables.
// - Three monitors flag slow references or feedback.
// - Threshold register picks normal or extended threshold.
// - Lock after N good cycles, drop on one bad.
`include "phc_defines.vh"

module phc_holdover (
  // AHB-Lite slave
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output wire [31:0] hrdata,
  // Pins and clocks from outside the clock domain
  input  wire        alignment_pin_n,
  input  wire        lock_comparator_in,
  input  wire        reference_input_a,
  input  wire        reference_input_b,
  input  wire        feedback_clk_in,
  // Lock indicator pin drive
  output wire        lock_indicator_pin_out,
  output wire        lock_indicator_pin_oe,
  output wire        lock_indicator_cs_mode,
  // Charge pump and feedback divider
  output wire        charge_pump_up,
  output wire        charge_pump_down,
  output wire        charge_pump_oe,
  output wire        b_counter_reset,
  // Distribution and status
  output wire [3:0]  dist_output_en,
  output wire        holdover_active,
  output wire [2:0]  freq_monitor_low
);

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  localparam NSYNC = 5;
  wire [NSYNC-1:0] pin_raw;
  reg  [NSYNC-1:0] sync1_reg;
  reg  [NSYNC-1:0] sync2_reg;
  reg  [NSYNC-1:0] sync3_reg;
  wire [NSYNC-1:0] rise;
  wire [NSYNC-1:0] fall;
  genvar g;

  assign pin_raw = {feedback_clk_in, reference_input_b, reference_input_a,
                    lock_comparator_in, alignment_pin_n};

  generate
    for (g = 0; g < NSYNC; g = g + 1) begin : g_sync
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync1_reg[g] <= 1'b1;
          sync2_reg[g] <= 1'b1;
          sync3_reg[g] <= 1'b1;
        end else begin
          sync1_reg[g] <= pin_raw[g];
          sync2_reg[g] <= sync1_reg[g];
          sync3_reg[g] <= sync2_reg[g];
        end
      end
      assign rise[g] = sync2_reg[g] & ~sync3_reg[g];
      assign fall[g] = ~sync2_reg[g] & sync3_reg[g];
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg  [7:0]  ldc_reg;
  reg  [7:0]  lpc_reg;
  reg  [7:0]  rsc_reg;
  reg  [7:0]  hoc_reg;
  reg  [7:0]  rmt_reg;
  reg  [7:0]  ch_reg [0:3];
  reg         wr_pend_reg;
  reg  [8:0]  wr_idx_reg;
  reg         rd_wait_reg;
  reg  [8:0]  rd_idx_reg;
  reg  [31:0] hrdata_reg;
  reg  [7:0]  rd_val;
  wire        acc;
  wire [8:0]  acc_idx;
  wire [7:0]  status_val;

  assign acc       = hsel & hready & htrans[1];
  assign acc_idx   = haddr[10:2];
  assign hreadyout = ~rd_wait_reg;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  always @* begin
    case (rd_idx_reg)
      `PHC_IDX_LOCK_DETECT_CONFIG: rd_val = ldc_reg;
      `PHC_IDX_LOCK_PIN_CONTROL:   rd_val = lpc_reg;
      `PHC_IDX_REFERENCE_SELECT:   rd_val = rsc_reg;
      `PHC_IDX_HOLDOVER_CONTROL:   rd_val = hoc_reg;
      `PHC_IDX_REF_MON_THRESHOLD:  rd_val = rmt_reg;
      `PHC_IDX_STATUS:             rd_val = status_val;
      `PHC_IDX_CH0_CONTROL:        rd_val = ch_reg[0];
      `PHC_IDX_CH0_CONTROL + 9'h003: rd_val = ch_reg[1];
      `PHC_IDX_CH0_CONTROL + 9'h006: rd_val = ch_reg[2];
      `PHC_IDX_CH0_CONTROL + 9'h009: rd_val = ch_reg[3];
      default:                     rd_val = 8'h00;
    endcase
  end

  // Reads take one wait state so that hrdata comes from a flip-flop and a
  // write in the preceding data phase is already visible.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 9'h000;
      rd_wait_reg <= 1'b0;
      rd_idx_reg  <= 9'h000;
      hrdata_reg  <= 32'h00000000;
    end else begin
      wr_pend_reg <= acc & hwrite;
      rd_wait_reg <= acc & ~hwrite;
      if (acc) begin
        wr_idx_reg <= acc_idx;
        rd_idx_reg <= acc_idx;
      end
      if (rd_wait_reg) begin
        hrdata_reg <= {24'h000000, rd_val};
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ldc_reg <= `PHC_RST_LDC;
      lpc_reg <= `PHC_RST_LPC;
      rsc_reg <= `PHC_RST_RSC;
      hoc_reg <= `PHC_RST_HOC;
      rmt_reg <= `PHC_RST_RMT;
    end else if (wr_pend_reg) begin
      case (wr_idx_reg)
        `PHC_IDX_LOCK_DETECT_CONFIG: ldc_reg <= hwdata[7:0];
        `PHC_IDX_LOCK_PIN_CONTROL:   lpc_reg <= hwdata[7:0];
        `PHC_IDX_REFERENCE_SELECT:   rsc_reg <= hwdata[7:0];
        `PHC_IDX_HOLDOVER_CONTROL:   hoc_reg <= hwdata[7:0];
        `PHC_IDX_REF_MON_THRESHOLD:  rmt_reg <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  generate
    for (g = 0; g < 4; g = g + 1) begin : g_ch
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ch_reg[g] <= `PHC_RST_CH;
        end else if (wr_pend_reg &&
                     wr_idx_reg == `PHC_IDX_CH0_CONTROL + g * `PHC_IDX_CH_STRIDE) begin
          ch_reg[g] <= hwdata[7:0];
        end
      end
      // A low alignment level stops the channel unless it is told to ignore it.
      assign dist_output_en[g] = ch_reg[g][`PHC_CH_IGNORE_ALIGN] | sync2_reg[0];
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Frequency monitors and reference selection
  // --------------------------------------------------------------------------
  reg  [9:0] mon_cnt_reg [0:2];
  reg  [2:0] mon_low_reg;
  wire [9:0] mon_lim [0:2];
  wire [2:0] mon_edge;
  wire       buf_a;
  wire       buf_b;
  wire       sel_b;
  wire       pref_b;
  wire       ref_edge;
  wire       fb_edge;

  assign buf_a   = rsc_reg[`PHC_RSC_BUF_A];
  assign buf_b   = rsc_reg[`PHC_RSC_BUF_B];
  assign mon_edge = {rise[4], rise[3] & buf_b, rise[2] & buf_a};
  assign mon_lim[0] = rmt_reg[`PHC_RMT_EXT_A] ? `PHC_MON_EXT_CYC
                                              : `PHC_MON_NORM_CYC;
  assign mon_lim[1] = rmt_reg[`PHC_RMT_EXT_B] ? `PHC_MON_EXT_CYC
                                              : `PHC_MON_NORM_CYC;
  assign mon_lim[2] = `PHC_MON_CLK_CYC;

  generate
    for (g = 0; g < 3; g = g + 1) begin : g_mon
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          mon_cnt_reg[g] <= 10'h000;
          mon_low_reg[g] <= 1'b1;
        end else if (mon_edge[g]) begin
          mon_cnt_reg[g] <= 10'h000;
          mon_low_reg[g] <= (mon_cnt_reg[g] >= mon_lim[g]);
        end else if (mon_cnt_reg[g] >= mon_lim[g]) begin
          mon_low_reg[g] <= 1'b1;
        end else begin
          mon_cnt_reg[g] <= mon_cnt_reg[g] + 10'h001;
        end
      end
    end
  endgenerate

  assign freq_monitor_low = mon_low_reg;

  // Automatic switchover reverts to the preferred input once it recovers.
  assign pref_b   = rsc_reg[`PHC_RSC_PREFER_B];
  assign sel_b    = rsc_reg[`PHC_RSC_AUTO] ?
                    (pref_b ? ~(mon_low_reg[1] & ~mon_low_reg[0])
                            : (mon_low_reg[0] & ~mon_low_reg[1])) : pref_b;
  assign ref_edge = sel_b ? mon_edge[1] : mon_edge[0];
  assign fb_edge  = rise[4];

  // --------------------------------------------------------------------------
  // Digital lock detector and lock pin drive
  // --------------------------------------------------------------------------
  reg  [1:0] pd_state_reg;
  reg  [7:0] pd_cnt_reg;
  reg  [7:0] good_cnt_reg;
  reg        dld_lock_reg;
  reg        pump_up_reg;
  reg        pump_dn_reg;
  reg        diff_vld;
  reg  [7:0] diff;
  reg  [7:0] lock_need;
  wire [7:0] win;
  wire [7:0] unwin;
  localparam PD_IDLE = 2'b00;
  localparam PD_REF  = 2'b01;
  localparam PD_FB   = 2'b10;

  assign win   = ldc_reg[`PHC_LDC_WINDOW] ? `PHC_LOCK_WIN_LO_CYC
                                          : `PHC_LOCK_WIN_HI_CYC;
  assign unwin = ldc_reg[`PHC_LDC_WINDOW] ? `PHC_UNLOCK_LO_CYC
                                          : `PHC_UNLOCK_HI_CYC;

  always @* begin
    case (ldc_reg[`PHC_LDC_CNT_HI:`PHC_LDC_CNT_LO])
      2'b00:   lock_need = `PHC_LOCK_CNT_00;
      2'b01:   lock_need = `PHC_LOCK_CNT_01;
      2'b10:   lock_need = `PHC_LOCK_CNT_10;
      default: lock_need = `PHC_LOCK_CNT_11;
    endcase
    diff_vld = 1'b0;
    diff     = 8'h00;
    case (pd_state_reg)
      PD_IDLE: begin
        diff_vld = ref_edge & fb_edge;
      end
      PD_REF: begin
        diff_vld = fb_edge;
        diff     = pd_cnt_reg;
      end
      PD_FB: begin
        diff_vld = ref_edge;
        diff     = pd_cnt_reg;
      end
      default: ;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pd_state_reg <= PD_IDLE;
      pd_cnt_reg   <= 8'h00;
      good_cnt_reg <= 8'h00;
      dld_lock_reg <= 1'b0;
      pump_up_reg  <= 1'b0;
      pump_dn_reg  <= 1'b0;
    end else begin
      if (pd_cnt_reg != 8'hFF) begin
        pd_cnt_reg <= pd_cnt_reg + 8'h01;
      end
      case (pd_state_reg)
        PD_IDLE: begin
          pd_cnt_reg <= 8'h00;
          if (ref_edge && !fb_edge) begin
            pd_state_reg <= PD_REF;
            pump_up_reg  <= 1'b1;
          end else if (fb_edge && !ref_edge) begin
            pd_state_reg <= PD_FB;
            pump_dn_reg  <= 1'b1;
          end
        end
        PD_REF, PD_FB: begin
          if (diff_vld) begin
            pd_state_reg <= PD_IDLE;
            pump_up_reg  <= 1'b0;
            pump_dn_reg  <= 1'b0;
          end
        end
        default: pd_state_reg <= PD_IDLE;
      endcase
      if (ldc_reg[`PHC_LDC_DISABLE]) begin
        good_cnt_reg <= 8'h00;
        dld_lock_reg <= 1'b0;
      end else if (diff_vld) begin
        if (dld_lock_reg && diff > unwin) begin
          dld_lock_reg <= 1'b0;
          good_cnt_reg <= 8'h00;
        end else if (!dld_lock_reg && diff < win) begin
          if (good_cnt_reg + 8'h01 >= lock_need) begin
            dld_lock_reg <= 1'b1;
          end else begin
            good_cnt_reg <= good_cnt_reg + 8'h01;
          end
        end else if (!dld_lock_reg) begin
          good_cnt_reg <= 8'h00;
        end
      end
    end
  end

  // In current-source mode the pin sources charge while locked and is pulled
  // low when not, so the external capacitor filters lock chatter.
  assign lock_indicator_cs_mode = (lpc_reg[`PHC_LPC_MODE_HI:0] == `PHC_LPC_CURRENT_SRC);
  assign lock_indicator_pin_out = dld_lock_reg;
  assign lock_indicator_pin_oe  = lock_indicator_cs_mode |
                                  (lpc_reg[`PHC_LPC_MODE_HI:0] == `PHC_LPC_DIGITAL);

  // --------------------------------------------------------------------------
  // Holdover control
  // --------------------------------------------------------------------------
  reg  hold_reg;
  reg  armed_reg;
  reg  brst_reg;
  wire hold_en;
  wire manual;
  wire ld_sensed;
  wire enter;
  wire leave;

  assign hold_en   = hoc_reg[`PHC_HOC_ENABLE];
  assign manual    = hoc_reg[`PHC_HOC_EXTERNAL];
  assign ld_sensed = hoc_reg[`PHC_HOC_COMP_EN] ? sync2_reg[1] : 1'b1;
  assign enter     = hold_en & (manual ? fall[0] : (armed_reg & ~ld_sensed));
  // Release waits for a reference edge; without one the pump stays off.
  assign leave     = hold_reg & ref_edge & (~manual | sync2_reg[0]);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_reg  <= 1'b0;
      armed_reg <= 1'b1;
      brst_reg  <= 1'b0;
    end else begin
      brst_reg <= 1'b0;
      if (!hold_en) begin
        hold_reg  <= 1'b0;
        armed_reg <= 1'b1;
      end else if (!hold_reg) begin
        if (enter) begin
          hold_reg  <= 1'b1;
          armed_reg <= 1'b0;
        end else if (ld_sensed) begin
          armed_reg <= 1'b1;
        end
      end else if (leave) begin
        hold_reg <= 1'b0;
        brst_reg <= 1'b1;
      end
    end
  end

  assign holdover_active  = hold_reg;
  assign charge_pump_oe   = ~hold_reg;
  assign charge_pump_up   = pump_up_reg & ~hold_reg;
  assign charge_pump_down = pump_dn_reg & ~hold_reg;
  assign b_counter_reset  = brst_reg;

  assign status_val = {2'b00, mon_low_reg, dld_lock_reg, sel_b, hold_reg};

endmodule

// *** tb/phc_ref_model.sv ***
// Behavioural far side: two reference clocks and the external feedback clock.
`timescale 1ns/100ps
module phc_ref_model (
  // Controls from the bench
  input  wire        run_a,
  input  wire        run_b,
  input  wire [15:0] half_a,
  input  wire [15:0] half_b,
  input  wire [1:0]  fb_mode,
  // Clocks toward the block
  output reg         ref_a,
  output reg         ref_b,
  output wire        fb_clk
);
  // A stopped reference stands low, as a lost clock would.
  initial begin
    ref_a = 1'b0;
    #1;
    forever begin
      #(half_a);
      ref_a = run_a ? ~ref_a : 1'b0;
    end
  end
  initial begin
    ref_b = 1'b0;
    #1;
    forever begin
      #(half_b);
      ref_b = run_b ? ~ref_b : 1'b0;
    end
  end
  // Mode 1 is in phase with reference a, mode 2 lags it by half a period.
  assign fb_clk = (fb_mode == 2'h1) ? ref_a : ((fb_mode == 2'h2) ? ~ref_a : 1'b0);
endmodule

// *** tb/phc_holdover_props.sv ***
// Port assertions for the holdover controller, bound to its top module.
`timescale 1ns/100ps
module phc_holdover_props (
  // Bus and clock
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire        hreadyout,
  input wire [31:0] hrdata,
  // Pins and outputs
  input wire        alignment_pin_n,
  input wire        reference_input_a,
  input wire        reference_input_b,
  input wire        feedback_clk_in,
  input wire        lock_indicator_pin_oe,
  input wire        lock_indicator_cs_mode,
  input wire        charge_pump_up,
  input wire        charge_pump_down,
  input wire        charge_pump_oe,
  input wire        b_counter_reset,
  input wire [3:0]  dist_output_en,
  input wire        holdover_active,
  input wire [2:0]  freq_monitor_low
);
  reg       ra_q;
  reg       rb_q;
  reg       fb_q;
  reg [9:0] ref_age;
  reg [9:0] a_age;
  reg [9:0] fb_age;
  function [9:0] sat(input [9:0] v);
    sat = (v == 10'h3FF) ? v : v + 10'h001;
  endfunction
  // Ages saturate so that a long stop never wraps back to a small count.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ra_q    <= 1'b0;
      rb_q    <= 1'b0;
      fb_q    <= 1'b0;
      ref_age <= 10'h000;
      a_age   <= 10'h000;
      fb_age  <= 10'h000;
    end else begin
      ra_q    <= reference_input_a;
      rb_q    <= reference_input_b;
      fb_q    <= feedback_clk_in;
      ref_age <= (ra_q != reference_input_a || rb_q != reference_input_b) ? 10'h000 : sat(ref_age);
      a_age   <= (ra_q != reference_input_a) ? 10'h000 : sat(a_age);
      fb_age  <= (fb_q != feedback_clk_in) ? 10'h000 : sat(fb_age);
    end
  end
  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_req;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  rd_wait_a: assert property (rd_req |=> rd_wait)
    else $error("read wait state wrong");
  wr_zero_a: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
    else $error("write was stalled");
  rdata_wide_a: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  cp_hiz_a: assert property (holdover_active |-> !charge_pump_oe && !charge_pump_up && !charge_pump_down)
    else $error("charge pump driven in holdover");
  exit_pulse_a: assert property (b_counter_reset |-> $fell(holdover_active))
    else $error("counter reset away from exit");
  pulse_one_a: assert property (b_counter_reset |=> !b_counter_reset)
    else $error("counter reset longer than one cycle");
  exit_edge_a: assert property (b_counter_reset |-> ref_age < 10'd8)
    else $error("exit without reference edge");
  dist_align_a: assert property (alignment_pin_n [*4] |-> dist_output_en == 4'hF)
    else $error("outputs off with alignment high");
  cs_oe_a: assert property (lock_indicator_cs_mode |-> lock_indicator_pin_oe)
    else $error("current source mode not driving");
  mon_a_a: assert property (a_age > 10'd600 |-> freq_monitor_low[0])
    else $error("stopped reference not flagged");
  mon_fb_a: assert property (fb_age > 10'd600 |-> freq_monitor_low[2])
    else $error("stopped feedback not flagged");
endmodule
bind phc_holdover phc_holdover_props phc_holdover_props_i (.hclk, .hresetn, .hsel, .htrans,
  .hwrite, .hready, .hreadyout, .hrdata, .alignment_pin_n, .reference_input_a,
  .reference_input_b, .feedback_clk_in, .lock_indicator_pin_oe, .lock_indicator_cs_mode,
  .charge_pump_up, .charge_pump_down, .charge_pump_oe, .b_counter_reset, .dist_output_en,
  .holdover_active, .freq_monitor_low);

// *** tb/test_phc_holdover.sv ***
// Self-checking bench for the holdover controller.
`timescale 1ns/100ps
`include "phc_defines.vh"
module test_phc_holdover;
  reg         hclk = 1'b0;
  reg         hresetn = 1'b0;
  reg         hsel = 1'b0;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  reg         align_n = 1'b1;
  reg         lock_cmp = 1'b0;
  reg         run_a = 1'b1;
  reg         run_b = 1'b1;
  reg  [15:0] half_a = 16'h003C;
  reg  [15:0] half_b = 16'h003C;
  reg  [1:0]  fb_mode = 2'h1;
  wire        hreadyout;
  wire        hresp;
  wire [31:0] hrdata;
  wire        ref_a;
  wire        ref_b;
  wire        fb;
  wire        lk_out;
  wire        lk_oe;
  wire        lk_cs;
  wire        cp_up;
  wire        cp_dn;
  wire        cp_oe;
  wire        bcr;
  wire [3:0]  dist_en;
  wire        hold;
  wire [2:0]  mon;
  integer     n_fail = 0;
  integer     n_tests = 0;
  integer     cyc = 0;
  integer     n_bcr = 0;
  integer     c;
  reg  [31:0] rd;
  reg  [8:0]  ix [0:5] = '{`PHC_IDX_LOCK_DETECT_CONFIG, `PHC_IDX_LOCK_PIN_CONTROL,
    `PHC_IDX_REFERENCE_SELECT, `PHC_IDX_HOLDOVER_CONTROL, `PHC_IDX_REF_MON_THRESHOLD, 9'h0FF};
  reg  [7:0]  rv [0:5] = '{`PHC_RST_LDC, `PHC_RST_LPC, `PHC_RST_RSC, `PHC_RST_HOC,
    `PHC_RST_RMT, 8'h00};
  phc_holdover phc_holdover_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .alignment_pin_n(align_n),
    .lock_comparator_in(lock_cmp), .reference_input_a(ref_a), .reference_input_b(ref_b),
    .feedback_clk_in(fb), .lock_indicator_pin_out(lk_out), .lock_indicator_pin_oe(lk_oe),
    .lock_indicator_cs_mode(lk_cs), .charge_pump_up(cp_up), .charge_pump_down(cp_dn),
    .charge_pump_oe(cp_oe), .b_counter_reset(bcr), .dist_output_en(dist_en),
    .holdover_active(hold), .freq_monitor_low(mon));
  phc_ref_model phc_ref_model_i (.run_a(run_a), .run_b(run_b), .half_a(half_a),
    .half_b(half_b), .fb_mode(fb_mode), .ref_a(ref_a), .ref_b(ref_b), .fb_clk(fb));
  always #4 hclk = ~hclk;
  // A hang anywhere ends the run through the verdict with a mismatch counted.
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (bcr === 1'b1)
      n_bcr <= n_bcr + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      print_verdict;
    end
  end
  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // Ready is read at the rising edge, before that edge's updates land.
  task bus(input w, input [8:0] idx, input [7:0] d);
    begin
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {21'h0, idx, 2'h0};
      @(posedge hclk);
      while (hreadyout !== 1'b1)
        @(posedge hclk);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      @(posedge hclk);
      while (hreadyout !== 1'b1)
        @(posedge hclk);
      rd = hrdata;
    end
  endtask
  task wait_hold(input v, input integer lim);
    integer k;
    begin
      k = 0;
      while (hold !== v && k < lim) begin
        @(negedge hclk);
        k = k + 1;
      end
      chk(hold, v);
    end
  endtask
  task stay_hold(input v, input integer n);
    repeat (n) begin
      @(negedge hclk);
      chk(hold, v);
    end
  endtask
  task set_refs(input v);
    begin
      @(posedge hclk);
      run_a <= v;
      run_b <= v;
      repeat (20) @(posedge hclk);
    end
  endtask
  task t_regs;
    integer i;
    begin
      chk(hold, 1'b0);
      chk(cp_oe, 1'b1);
      chk(hresp, 1'b0);
      for (i = 0; i < 6; i = i + 1) begin
        bus(1'b0, ix[i], 8'h00);
        chk(rd, rv[i]);
        bus(1'b1, ix[i], 8'h5A);
        bus(1'b0, ix[i], 8'h00);
        chk(rd, (i == 5) ? 32'h0 : 32'h5A);
        bus(1'b1, ix[i], rv[i]);
      end
      $display("registers test done");
    end
  endtask
  task t_gate;
    reg [8:0] ci;
    begin
      bus(1'b1, `PHC_IDX_HOLDOVER_CONTROL, 8'h02);
      @(posedge hclk);
      align_n <= 1'b0;
      stay_hold(1'b0, 20);
      chk(dist_en, 32'h0);
      @(posedge hclk);
      align_n <= 1'b1;
      ci = `PHC_IDX_CH0_CONTROL;
      repeat (4) begin
        bus(1'b1, ci, 8'h40);
        ci = ci + `PHC_IDX_CH_STRIDE;
      end
      $display("gating test done");
    end
  endtask
  task t_manual;
    begin
      bus(1'b1, `PHC_IDX_HOLDOVER_CONTROL, 8'h03);
      set_refs(1'b0);
      c = n_bcr;
      @(posedge hclk);
      align_n <= 1'b0;
      wait_hold(1'b1, 8);
      chk(cp_oe, 1'b0);
      chk(dist_en, 32'hF);
      @(posedge hclk);
      align_n <= 1'b1;
      stay_hold(1'b1, 30);
      set_refs(1'b1);
      wait_hold(1'b0, 40);
      chk(n_bcr, c + 1);
      $display("manual holdover test done");
    end
  endtask
  task t_auto;
    begin
      bus(1'b1, `PHC_IDX_HOLDOVER_CONTROL, 8'h01);
      stay_hold(1'b0, 20);
      bus(1'b1, `PHC_IDX_LOCK_DETECT_CONFIG, 8'h00);
      bus(1'b1, `PHC_IDX_LOCK_PIN_CONTROL, `PHC_LPC_CURRENT_SRC);
      @(posedge hclk);
      lock_cmp <= 1'b1;
      bus(1'b1, `PHC_IDX_HOLDOVER_CONTROL, 8'h09);
      set_refs(1'b0);
      c = n_bcr;
      @(posedge hclk);
      lock_cmp <= 1'b0;
      wait_hold(1'b1, 8);
      stay_hold(1'b1, 30);
      set_refs(1'b1);
      wait_hold(1'b0, 40);
      chk(n_bcr, c + 1);
      stay_hold(1'b0, 40);
      $display("automatic holdover test done");
    end
  endtask
  task t_lock;
    integer k;
    begin
      bus(1'b1, `PHC_IDX_LOCK_DETECT_CONFIG, 8'h00);
      bus(1'b1, `PHC_IDX_LOCK_PIN_CONTROL, `PHC_LPC_CURRENT_SRC);
      @(negedge hclk);
      chk(lk_cs, 1'b1);
      chk(lk_oe, 1'b1);
      @(posedge hclk);
      // A longer period makes the half-period lag clearly exceed the unlock window.
      half_a  <= 16'h0064;
      fb_mode <= 2'h2;
      repeat (60) @(negedge hclk);
      chk(lk_out, 1'b0);
      @(posedge hclk);
      fb_mode <= 2'h1;
      repeat (45) @(negedge hclk);
      chk(lk_out, 1'b0);
      for (k = 0; k < 150 && lk_out !== 1'b1; k = k + 1)
        @(negedge hclk);
      chk(lk_out, 1'b1);
      @(posedge hclk);
      fb_mode <= 2'h2;
      repeat (60) @(negedge hclk);
      chk(lk_out, 1'b0);
      $display("lock detect test done");
    end
  endtask
  task t_mon;
    begin
      @(posedge hclk);
      half_b  <= 16'd400;
      run_a   <= 1'b0;
      fb_mode <= 2'h0;
      repeat (700) @(negedge hclk);
      chk(mon, 32'h7);
      bus(1'b1, `PHC_IDX_REF_MON_THRESHOLD, 8'h04);
      repeat (700) @(negedge hclk);
      chk(mon, 32'h5);
      $display("monitor test done");
    end
  endtask
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_gate;
    t_manual;
    t_auto;
    t_lock;
    t_mon;
    print_verdict;
  end
endmodule
